// file: hw/dsl_frame_pkg.sv
package dsl_frame_pkg;
    // Frame layout in bit indices, sync first, stuffing last
    localparam logic [13:0] SYNC_WORD = 14'h2a08;
    localparam logic [3:0] SYNC_MSB = 4'hd;
    localparam logic [13:0] EOC_POS = 14'h000e;
    localparam logic [13:0] CRC_POS = 14'h001b;
    localparam logic [13:0] IND_POS = 14'h0021;
    localparam logic [13:0] PAY_POS = 14'h0030;
    localparam logic [13:0] OVH_LAST = 14'h002f;
    localparam logic [13:0] FRAME_LAST = 14'h3653;
    localparam logic [13:0] STUFF_LAST = 14'h3657;
    localparam logic [13:0] RX_IDLE = 14'h3fff;
    localparam logic [3:0] STUFF_PAT = 4'ha;
    localparam logic [1:0] STUFF_MSB = 2'h3;
    // Check code generator x^6 + x + 1
    localparam logic [5:0] CRC_POLY = 6'h03;
    localparam logic [5:0] CRC_INIT = 6'h00;
    // Scrambler order and direction taps
    localparam int SCR_ORDER = 23;
    localparam int TAP_NT2LT = 18;
    localparam int TAP_LT2NT = 5;
    // Indicator field, 15 bits, sent MSB first
    localparam logic [14:0] IND_IDLE = 15'h7fff;
    localparam int IND_LOSD = 14;
    localparam int IND_FEBE = 13;
    localparam int IND_PS1 = 12;
    localparam int IND_PS2 = 11;
    localparam int IND_BPV = 10;
    localparam int IND_HRP = 9;
    localparam int IND_RRBE = 8;
    localparam int IND_RCBE = 7;
    localparam int IND_RTA = 6;
    localparam int IND_REGA = 5;
    localparam int IND_RDY = 4;
    localparam int FIFO_DEPTH = 16;

    // One serial step of the check-code division
    function automatic logic [5:0] crc6_step(input logic [5:0] r, input logic b);
        logic fb;
        fb = b ^ r[5];
        return {r[4:0], 1'b0} ^ (fb ? CRC_POLY : CRC_INIT);
    endfunction : crc6_step
endpackage : dsl_frame_pkg

// file: hw/dsl_link_if.sv
`timescale 1ns/1ps
`default_nettype none
// One serial bit stream each way, frame start marked with the first sync bit
interface dsl_link_if;
    logic lt2nt_bit;
    logic lt2nt_sof;
    logic nt2lt_bit;
    logic nt2lt_sof;
    modport lt_end (output lt2nt_bit, output lt2nt_sof, input nt2lt_bit, input nt2lt_sof);
    modport nt_end (output nt2lt_bit, output nt2lt_sof, input lt2nt_bit, input lt2nt_sof);
endinterface : dsl_link_if
`default_nettype wire

// file: hw/nt_end.sv
// How it works
// RULE1 - Unassigned overhead bits are sent as ONE
// RULE2 - Every frame opens with the fixed sync word
// RULE3 - No application signal clears loss indicator next frame
// RULE4 - Local check mismatch clears far-end error bit
// RULE5 - Far-end error bit ONE without a new failure
// RULE6 - Thirteen maintenance bits per frame reach handler
// RULE7 - Check covers frame minus sync, check, stuffing
// RULE8 - Divide by x^6+x+1, highest coefficient first
// RULE9 - First frame check bits may be arbitrary
// RULE10 - Network terminal sends two-bit power status code
// RULE11 - Code violation in frame clears next violation bit
// RULE12 - Repeater clears presence bit, terminals send ONE
// RULE13 - Repeater line-side check error clears first bit
// RULE14 - Repeater terminal-side check error clears second bit
// RULE15 - Network terminal alarm bit low while alarm pending
// RULE16 - Repeater alarm bit low while alarm pending
// RULE17 - Stuffing is zero or two quats, unscrambled
// RULE18 - Ready indicator low only when ready to receive
// RULE19 - Scramble all but sync and stuffing bits
// RULE20 - Taps 23/18 toward line, 23/5 toward network
// RULE21 - Receiver descrambles with the same direction taps
// RULE22 - Receiver compares remainder with next frame's check
`timescale 1ns/1ps
`default_nettype none

// Synchronous FIFO; ready is registered so the source sees back-pressure
module dsl_fifo
    import dsl_frame_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] rd_reg;
    logic [AW:0] count_reg;
    logic [AW:0] count_next;
    logic push;
    logic pop;

    assign out_valid = (count_reg != '0);
    assign out_data = mem[rd_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Occupancy and pointers
    always_comb begin
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
            count_reg <= '0;
            in_ready <= 1'b0;
        end else begin
            if (push) wr_reg <= wr_reg + 1'b1;
            if (pop) rd_reg <= rd_reg + 1'b1;
            count_reg <= count_next;
            in_ready <= (count_next != (AW+1)'(DEPTH));
        end
    end

    // Storage has no reset; only valid words are ever read
    always_ff @(posedge clk_sys) begin
        if (push) mem[wr_reg] <= in_data;
    end
endmodule : dsl_fifo

// Self-synchronising scrambler or descrambler, order 23
module dsl_scrambler
    import dsl_frame_pkg::*;
#(
    parameter int TAP = TAP_NT2LT,
    parameter bit DESCR = 1'b0
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic en,
    input wire logic in_bit,
    output logic out_bit
);
    logic [SCR_ORDER-1:0] hist_reg;

    assign out_bit = in_bit ^ hist_reg[TAP-1] ^ hist_reg[SCR_ORDER-1]; // RULE20 RULE21

    // History holds line bits, so both ends lock without a shared seed
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hist_reg <= '0;
        end else if (en) begin
            hist_reg <= {hist_reg[SCR_ORDER-2:0], DESCR ? in_bit : out_bit};
        end
    end
endmodule : dsl_scrambler

// Framer, check code and scrambling shared by both ends
module dsl_frame_core
    import dsl_frame_pkg::*;
#(
    parameter int TX_TAP = TAP_NT2LT,
    parameter int RX_TAP = TAP_LT2NT
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [14:0] ind_in,
    input wire logic [12:0] eoc_in,
    output logic ovh_take,
    input wire logic pay_bit,
    input wire logic pay_valid,
    output logic pay_ready,
    input wire logic stuff_req,
    output logic tx_bit,
    output logic tx_sof,
    input wire logic rx_bit,
    input wire logic rx_sof,
    output logic [14:0] far_ind,
    output logic [12:0] eoc_rx,
    output logic eoc_rx_valid,
    output logic rx_pay,
    output logic rx_pay_valid,
    output logic crc_err,
    output logic sync_err
);
    logic [13:0] cnt_reg;
    logic stuff_now_reg;
    logic [33:0] ovh_sh_reg;
    logic [5:0] crc_acc_reg;
    logic raw;
    logic scr_en;
    logic scr_out;
    logic in_ovh;
    logic in_pay;
    logic cov;
    logic [13:0] ri;
    logic [13:0] ridx_reg;
    logic r_ovh;
    logic r_pay;
    logic r_scr;
    logic d;
    logic [33:0] rsh_next;
    logic [33:0] rsh_reg;
    logic [5:0] racc_reg;
    logic [5:0] racc_next;
    logic [5:0] rem_prev_reg;
    logic have_prev_reg;
    logic sync_bad_reg;
    logic sync_bad_next;

    // Transmit field decode
    always_comb begin
        in_ovh = (cnt_reg >= EOC_POS) && (cnt_reg < PAY_POS);
        in_pay = (cnt_reg >= PAY_POS) && (cnt_reg <= FRAME_LAST);
        scr_en = (cnt_reg >= EOC_POS) && (cnt_reg <= FRAME_LAST); // RULE19
        cov = in_pay || (in_ovh && !((cnt_reg >= CRC_POS) && (cnt_reg < IND_POS))); // RULE7
        if (cnt_reg < EOC_POS) begin
            raw = SYNC_WORD[SYNC_MSB - cnt_reg[3:0]]; // RULE2
        end else if (in_ovh) begin
            raw = ovh_sh_reg[33];
        end else if (in_pay) begin
            raw = pay_valid ? pay_bit : 1'b1; // Idle fill when starved
        end else begin
            raw = STUFF_PAT[STUFF_MSB - cnt_reg[1:0]]; // RULE17
        end
    end

    assign ovh_take = (cnt_reg == '0);
    assign pay_ready = in_pay;

    dsl_scrambler #(.TAP(TX_TAP), .DESCR(1'b0)) u_scr (
        .clk_sys(clk_sys),
        .rst(rst),
        .en(scr_en),
        .in_bit(raw),
        .out_bit(scr_out)
    );

    // Frame counter; stuffing decided once per frame, zero or two quats
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_reg <= '0;
            stuff_now_reg <= 1'b0;
        end else begin
            if (ovh_take) stuff_now_reg <= stuff_req; // RULE17
            if (cnt_reg == (stuff_now_reg ? STUFF_LAST : FRAME_LAST)) begin
                cnt_reg <= '0;
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end

    // Overhead load and check over the frame just sent
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ovh_sh_reg <= '1;
            crc_acc_reg <= CRC_INIT; // RULE9
        end else begin
            if (ovh_take) begin
                ovh_sh_reg <= {eoc_in, crc_acc_reg, ind_in}; // RULE6
            end else if (in_ovh) begin
                ovh_sh_reg <= {ovh_sh_reg[32:0], 1'b1};
            end
            if (cov) begin
                crc_acc_reg <= crc6_step((cnt_reg == EOC_POS) ? CRC_INIT : crc_acc_reg, raw); // RULE8
            end
        end
    end

    // Line outputs; sync and stuffing bypass the scrambler
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            tx_bit <= 1'b1;
            tx_sof <= 1'b0;
        end else begin
            tx_bit <= scr_en ? scr_out : raw; // RULE19
            tx_sof <= ovh_take;
        end
    end

    // Receive field decode, index restarts on the frame marker
    always_comb begin
        ri = rx_sof ? 14'h0000 : ridx_reg;
        r_ovh = (ri >= EOC_POS) && (ri < PAY_POS);
        r_pay = (ri >= PAY_POS) && (ri <= FRAME_LAST);
        r_scr = (ri >= EOC_POS) && (ri <= FRAME_LAST);
        rsh_next = r_ovh ? {rsh_reg[32:0], d} : rsh_reg;
        racc_next = racc_reg;
        if (r_pay || (r_ovh && !((ri >= CRC_POS) && (ri < IND_POS)))) begin
            racc_next = crc6_step((ri == EOC_POS) ? CRC_INIT : racc_reg, d); // RULE22
        end
        sync_bad_next = sync_bad_reg;
        if (ri < EOC_POS) begin
            sync_bad_next = ((ri == '0) ? 1'b0 : sync_bad_reg)
                | (rx_bit != SYNC_WORD[SYNC_MSB - ri[3:0]]);
        end
    end

    dsl_scrambler #(.TAP(RX_TAP), .DESCR(1'b1)) u_descr (
        .clk_sys(clk_sys),
        .rst(rst),
        .en(r_scr),
        .in_bit(rx_bit),
        .out_bit(d)
    );

    // Receive index and check state
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ridx_reg <= RX_IDLE;
            rsh_reg <= '1;
            racc_reg <= CRC_INIT;
            rem_prev_reg <= CRC_INIT;
            have_prev_reg <= 1'b0;
            sync_bad_reg <= 1'b0;
        end else begin
            ridx_reg <= (ri >= STUFF_LAST) ? RX_IDLE : ri + 1'b1;
            rsh_reg <= rsh_next;
            racc_reg <= racc_next;
            sync_bad_reg <= sync_bad_next;
            // A short or missing frame leaves no result to compare
            if (ri == FRAME_LAST) begin
                rem_prev_reg <= racc_next;
                have_prev_reg <= 1'b1;
            end else if (ri == OVH_LAST || (rx_sof && ridx_reg <= FRAME_LAST)) begin
                have_prev_reg <= 1'b0;
            end
        end
    end

    // Overhead, payload and error outputs toward the user
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            far_ind <= IND_IDLE;
            eoc_rx <= '1;
            eoc_rx_valid <= 1'b0;
            rx_pay <= 1'b0;
            rx_pay_valid <= 1'b0;
            crc_err <= 1'b0;
            sync_err <= 1'b0;
        end else begin
            eoc_rx_valid <= (ri == OVH_LAST);
            crc_err <= (ri == OVH_LAST) && have_prev_reg
                && (rsh_next[20:15] != rem_prev_reg); // RULE22
            sync_err <= (ri == EOC_POS - 1'b1) && sync_bad_next;
            if (ri == OVH_LAST) begin
                eoc_rx <= rsh_next[33:21]; // RULE6
                far_ind <= rsh_next[14:0];
            end
            rx_pay <= d;
            rx_pay_valid <= r_pay;
        end
    end
endmodule : dsl_frame_core

// Network terminal end, or a repeater's network-facing half when asked
module nt_end
    import dsl_frame_pkg::*;
#(
    parameter bit IS_REPEATER = 1'b0
) (
    input wire logic clk_sys,
    input wire logic rst,
    dsl_link_if.nt_end link,
    input wire logic pay_in,
    input wire logic pay_in_valid,
    output logic pay_in_ready,
    output logic pay_out,
    output logic pay_out_valid,
    input wire logic [12:0] eoc_tx,
    output logic [12:0] eoc_rx,
    output logic eoc_rx_valid,
    input wire logic sig_absent,
    input wire logic code_violation,
    input wire logic primary_supply_flag,
    input wire logic secondary_supply_flag,
    input wire logic alarm_pending,
    input wire logic rx_ready,
    input wire logic far_side_crc_err,
    input wire logic stuff_req,
    output logic [14:0] far_ind,
    output logic crc_err,
    output logic sync_err
);
    logic take;
    logic crc_err_i;
    logic febe_pend_reg;
    logic bpv_pend_reg;
    logic rcbe_pend_reg;
    logic [14:0] ind;
    logic f_bit;
    logic f_valid;
    logic f_ready;

    // Events wait for the next frame; a set in the take cycle survives
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            febe_pend_reg <= 1'b0;
            bpv_pend_reg <= 1'b0;
            rcbe_pend_reg <= 1'b0;
        end else begin
            febe_pend_reg <= crc_err_i | (febe_pend_reg & ~take); // RULE4 RULE13
            bpv_pend_reg <= code_violation | (bpv_pend_reg & ~take); // RULE11
            rcbe_pend_reg <= far_side_crc_err | (rcbe_pend_reg & ~take); // RULE14
        end
    end

    // Outgoing indicator field
    always_comb begin
        ind = IND_IDLE; // RULE1
        ind[IND_LOSD] = ~sig_absent; // RULE3
        ind[IND_FEBE] = ~febe_pend_reg; // RULE5
        ind[IND_BPV] = ~bpv_pend_reg; // RULE11
        ind[IND_HRP] = ~IS_REPEATER; // RULE12
        ind[IND_RDY] = ~rx_ready; // RULE18
        if (IS_REPEATER) begin
            ind[IND_RRBE] = ~febe_pend_reg; // RULE13
            ind[IND_RCBE] = ~rcbe_pend_reg; // RULE14
            ind[IND_REGA] = ~alarm_pending; // RULE16
        end else begin
            ind[IND_PS1] = primary_supply_flag; // RULE10
            ind[IND_PS2] = secondary_supply_flag; // RULE10
            ind[IND_RTA] = ~alarm_pending; // RULE15
        end
    end

    dsl_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_data(pay_in),
        .in_valid(pay_in_valid),
        .in_ready(pay_in_ready),
        .out_data(f_bit),
        .out_valid(f_valid),
        .out_ready(f_ready)
    );

    dsl_frame_core #(.TX_TAP(TAP_NT2LT), .RX_TAP(TAP_LT2NT)) u_core (
        .clk_sys(clk_sys),
        .rst(rst),
        .ind_in(ind),
        .eoc_in(eoc_tx),
        .ovh_take(take),
        .pay_bit(f_bit),
        .pay_valid(f_valid),
        .pay_ready(f_ready),
        .stuff_req(stuff_req),
        .tx_bit(link.nt2lt_bit),
        .tx_sof(link.nt2lt_sof),
        .rx_bit(link.lt2nt_bit),
        .rx_sof(link.lt2nt_sof),
        .far_ind(far_ind),
        .eoc_rx(eoc_rx),
        .eoc_rx_valid(eoc_rx_valid),
        .rx_pay(pay_out),
        .rx_pay_valid(pay_out_valid),
        .crc_err(crc_err_i),
        .sync_err(sync_err)
    );

    assign crc_err = crc_err_i; // Already a flop inside the core
endmodule : nt_end
`default_nettype wire

// file: hw/lt_end.sv
`timescale 1ns/1ps
`default_nettype none
// Line terminal end; fields it has no use for go out as ONE
module lt_end
    import dsl_frame_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    dsl_link_if.lt_end link,
    input wire logic pay_in,
    input wire logic pay_in_valid,
    output logic pay_in_ready,
    output logic pay_out,
    output logic pay_out_valid,
    input wire logic [12:0] eoc_tx,
    output logic [12:0] eoc_rx,
    output logic eoc_rx_valid,
    input wire logic sig_absent,
    input wire logic code_violation,
    input wire logic rx_ready,
    input wire logic stuff_req,
    output logic [14:0] far_ind,
    output logic crc_err,
    output logic sync_err
);
    logic take;
    logic crc_err_i;
    logic febe_pend_reg;
    logic bpv_pend_reg;
    logic [14:0] ind;
    logic f_bit;
    logic f_valid;
    logic f_ready;

    // Pending events held until the next frame's overhead is loaded
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            febe_pend_reg <= 1'b0;
            bpv_pend_reg <= 1'b0;
        end else begin
            febe_pend_reg <= crc_err_i | (febe_pend_reg & ~take); // RULE4
            bpv_pend_reg <= code_violation | (bpv_pend_reg & ~take); // RULE11
        end
    end

    // Outgoing indicator field
    always_comb begin
        ind = IND_IDLE; // RULE1 RULE12
        ind[IND_LOSD] = ~sig_absent; // RULE3
        ind[IND_FEBE] = ~febe_pend_reg; // RULE5
        ind[IND_BPV] = ~bpv_pend_reg; // RULE11
        ind[IND_RDY] = ~rx_ready; // RULE18
    end

    dsl_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .rst(rst),
        .in_data(pay_in),
        .in_valid(pay_in_valid),
        .in_ready(pay_in_ready),
        .out_data(f_bit),
        .out_valid(f_valid),
        .out_ready(f_ready)
    );

    dsl_frame_core #(.TX_TAP(TAP_LT2NT), .RX_TAP(TAP_NT2LT)) u_core (
        .clk_sys(clk_sys),
        .rst(rst),
        .ind_in(ind),
        .eoc_in(eoc_tx),
        .ovh_take(take),
        .pay_bit(f_bit),
        .pay_valid(f_valid),
        .pay_ready(f_ready),
        .stuff_req(stuff_req),
        .tx_bit(link.lt2nt_bit),
        .tx_sof(link.lt2nt_sof),
        .rx_bit(link.nt2lt_bit),
        .rx_sof(link.nt2lt_sof),
        .far_ind(far_ind),
        .eoc_rx(eoc_rx),
        .eoc_rx_valid(eoc_rx_valid),
        .rx_pay(pay_out),
        .rx_pay_valid(pay_out_valid),
        .crc_err(crc_err_i),
        .sync_err(sync_err)
    );

    assign crc_err = crc_err_i; // Already a flop inside the core
endmodule : lt_end
`default_nettype wire

// file: test/dsl_link_props.sv
`timescale 1ns/1ps
`default_nettype none
// Framing checks on both line directions
module dsl_link_props
    import dsl_frame_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic lt2nt_bit,
    input wire logic lt2nt_sof,
    input wire logic nt2lt_bit,
    input wire logic nt2lt_sof
);
    logic [13:0] la_reg;
    logic [13:0] na_reg;
    logic [13:0] li;
    logic [13:0] ni;
    logic ls_reg;
    logic ns_reg;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Bit index of the current bit on each wire
    assign li = lt2nt_sof ? 14'h0000 : la_reg;
    assign ni = nt2lt_sof ? 14'h0000 : na_reg;
    // Counters need no reset, they are gated by the seen flags
    always_ff @(posedge clk_sys) begin
        la_reg <= li + 14'h0001;
        na_reg <= ni + 14'h0001;
    end
    // Index means nothing before the first frame mark
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ls_reg <= 1'b0;
            ns_reg <= 1'b0;
        end else begin
            ls_reg <= ls_reg | lt2nt_sof;
            ns_reg <= ns_reg | nt2lt_sof;
        end
    end
    lt_sync_word_a: assert property ((ls_reg || lt2nt_sof) && li <= 14'h000d
        |-> lt2nt_bit == SYNC_WORD[SYNC_MSB - li[3:0]]) else $error("lt sync word bad");
    nt_sync_word_a: assert property ((ns_reg || nt2lt_sof) && ni <= 14'h000d
        |-> nt2lt_bit == SYNC_WORD[SYNC_MSB - ni[3:0]]) else $error("nt sync word bad");
    lt_frame_len_a: assert property (ls_reg && lt2nt_sof |->
        la_reg == FRAME_LAST + 14'h0001 || la_reg == STUFF_LAST + 14'h0001)
        else $error("lt frame length bad");
    nt_frame_len_a: assert property (ns_reg && nt2lt_sof |->
        na_reg == FRAME_LAST + 14'h0001 || na_reg == STUFF_LAST + 14'h0001)
        else $error("nt frame length bad");
    lt_frame_bound_a: assert property (ls_reg |-> li <= STUFF_LAST)
        else $error("lt frame overrun");
    nt_frame_bound_a: assert property (ns_reg |-> ni <= STUFF_LAST)
        else $error("nt frame overrun");
    lt_stuff_bits_a: assert property (ls_reg && li > FRAME_LAST
        |-> lt2nt_bit == STUFF_PAT[STUFF_MSB - li[1:0]]) else $error("lt stuffing bad");
    nt_stuff_bits_a: assert property (ns_reg && ni > FRAME_LAST
        |-> nt2lt_bit == STUFF_PAT[STUFF_MSB - ni[1:0]]) else $error("nt stuffing bad");
endmodule : dsl_link_props
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
    import dsl_frame_pkg::*;
;
    localparam logic [15:0] PAT = 16'hc5a3;
    logic clk_sys, rst;
    logic l_pin, l_pv, l_sa, l_cv, l_rr, l_pir, l_po, l_pov, l_eov, l_crc, l_sync;
    logic n_sa, n_cv, n_p1, n_p2, n_al, n_rr, n_st, n_pir, n_po, n_pov, n_eov, n_crc, n_sync;
    logic [12:0] l_eoct, l_eoc, n_eoct, n_eoc;
    logic [14:0] l_far, n_far;
    int error_cnt = 0;
    int num_checks = 0;
    dsl_link_if link ();
    lt_end u_lt_end (.clk_sys(clk_sys), .rst(rst), .link(link), .pay_in(l_pin),
        .pay_in_valid(l_pv), .pay_in_ready(l_pir), .pay_out(l_po), .pay_out_valid(l_pov),
        .eoc_tx(l_eoct), .eoc_rx(l_eoc), .eoc_rx_valid(l_eov), .sig_absent(l_sa),
        .code_violation(l_cv), .rx_ready(l_rr), .stuff_req(1'b0), .far_ind(l_far),
        .crc_err(l_crc), .sync_err(l_sync));
    nt_end u_nt_end (.clk_sys(clk_sys), .rst(rst), .link(link), .pay_in(1'b0),
        .pay_in_valid(1'b0), .pay_in_ready(n_pir), .pay_out(n_po), .pay_out_valid(n_pov),
        .eoc_tx(n_eoct), .eoc_rx(n_eoc), .eoc_rx_valid(n_eov), .sig_absent(n_sa),
        .code_violation(n_cv), .primary_supply_flag(n_p1), .secondary_supply_flag(n_p2),
        .alarm_pending(n_al), .rx_ready(n_rr), .far_side_crc_err(1'b0), .stuff_req(n_st),
        .far_ind(n_far), .crc_err(n_crc), .sync_err(n_sync));
    dsl_link_props u_dsl_link_props (.clk_sys(clk_sys), .rst(rst),
        .lt2nt_bit(link.lt2nt_bit), .lt2nt_sof(link.lt2nt_sof),
        .nt2lt_bit(link.nt2lt_bit), .nt2lt_sof(link.nt2lt_sof));

    // Free-running system clock
    always #5 clk_sys = ~clk_sys;

    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [16:0] got, input logic [16:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic wait_sof(input bit to_lt);
        do @(negedge clk_sys);
        while ((to_lt ? link.nt2lt_sof : link.lt2nt_sof) !== 1'b1);
    endtask : wait_sof

    // Next frame's indicators and maintenance bits as seen by the far end
    task automatic run_ind(input bit to_lt, input logic [14:0] exp, input logic [12:0] eoc);
        wait_sof(to_lt);
        do @(negedge clk_sys);
        while ((to_lt ? l_eov : n_eov) !== 1'b1);
        check({2'h0, to_lt ? l_far : n_far}, {2'h0, exp});
        check({4'h0, to_lt ? l_eoc : n_eoc}, {4'h0, eoc});
        check({16'h0, to_lt ? l_crc : n_crc}, 17'h0);
    endtask : run_ind

    // Fill the line-terminal buffer in the overhead gap, then watch it drain
    task automatic fill_drain;
        logic [16:0] got;
        int n;
        int k;
        wait_sof(1'b0);
        wait_sof(1'b0);
        n = 0;
        repeat (20) begin
            l_pv = l_pir;
            l_pin = PAT[4'hf - n[3:0]];
            if (l_pir === 1'b1) n++;
            @(negedge clk_sys);
        end
        l_pv = 1'b0;
        check(17'(n), 17'd16);
        check({16'h0, l_pir}, 17'h0);
        do @(negedge clk_sys);
        while (n_eov !== 1'b1);
        k = 0;
        got = 17'h0;
        while (k < 17) begin
            @(negedge clk_sys);
            if (n_pov === 1'b1) begin
                got = {got[15:0], n_po};
                k++;
            end
        end
        check(got, {PAT, 1'b1});
    endtask : fill_drain

    // Network terminal sends every power code; first frame also raises events
    task automatic nt_side;
        logic [14:0] exp;
        wait_sof(1'b1);
        for (int k = 0; k < 4; k++) begin
            n_p1 = k[1];
            n_p2 = k[0];
            n_eoct = 13'h0a5c ^ 13'(k);
            n_sa = (k == 0);
            n_al = (k == 0);
            n_rr = (k == 0);
            n_st = (k == 1);
            n_cv = (k == 0);
            @(negedge clk_sys);
            n_cv = 1'b0;
            exp = 15'h7fff;
            exp[IND_PS1] = k[1];
            exp[IND_PS2] = k[0];
            if (k == 0) exp = exp & ~15'h4450;
            run_ind(1'b1, exp, n_eoct);
        end
    endtask : nt_side

    // Line terminal events, then a quiet frame with every indicator ONE
    task automatic lt_side;
        wait_sof(1'b0);
        l_sa = 1'b1;
        l_rr = 1'b1;
        l_cv = 1'b1;
        @(negedge clk_sys);
        l_cv = 1'b0;
        run_ind(1'b0, 15'h7fff & ~15'h4410, l_eoct);
        l_sa = 1'b0;
        l_rr = 1'b0;
        l_eoct = 13'h1234;
        run_ind(1'b0, 15'h7fff, 13'h1234);
    endtask : lt_side

    // Clean line must never flag check or sync faults
    always @(negedge clk_sys) begin
        if (!rst && (l_crc | n_crc | l_sync | n_sync) !== 1'b0) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, {l_crc, n_crc, l_sync, n_sync}, 4'h0);
        end
        // Network side sends only idle payload, so every descrambled bit is ONE
        if (!rst && l_pov === 1'b1 && l_po !== 1'b1) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, l_po, 1'b1);
        end
    end

    // Watchdog, about twice the expected run
    initial begin
        #1000000;
        error_cnt++;
        stop_test();
    end

    initial begin
        clk_sys = 1'b0;
        rst = 1'b1;
        {l_pin, l_pv, l_sa, l_cv, l_rr, n_sa, n_cv, n_al, n_rr, n_st} = '0;
        n_p1 = 1'b1;
        n_p2 = 1'b1;
        l_eoct = 13'h0a5c;
        n_eoct = 13'h0a5c;
        repeat (5) @(negedge clk_sys);
        check({2'h0, l_far}, 17'h07fff);
        check({4'h0, n_eoc}, 17'h01fff);
        check({16'h0, n_pir}, 17'h0);
        rst = 1'b0;
        fork
            fill_drain();
            nt_side();
            lt_side();
        join
        check({16'h0, n_pir}, 17'h1);
        stop_test();
    end
endmodule : tb
`default_nettype wire
